/* File: rtl/gp_timer.sv */
// General-purpose timer: two 16-bit halves or one 32-bit down-counter
// Behaviour
// - Two 16-bit halves run apart or joined as one 32-bit timer.
// - Reset leaves the block idle with all control registers at defaults.
// - Reset sets both half counters and both load registers to 0xFFFF.
// - Reset sets both prescale registers to zero.
// - Configuration 0 selects 32-bit timer; 1 (32-bit clock) joins the halves but never counts.
// - Configuration 4 splits into two 16-bit timers with own modes.
// - Configuration 4 acts as two timers; 16-bit halves run apart.
// - In 32-bit modes a lower load write fills both load halves.
// - In 32-bit modes lower count read returns upper:lower counts.
// - 32-bit timer mode comes from the lower mode field only.
// - Setting lower enable starts 32-bit countdown each clock.
// - At zero the counter reloads the joined load value next cycle.
// - One-shot: at zero counting stops and lower enable is cleared.
// - Periodic: after reload counting continues by itself.
// - Each zero raises the time-out event and a trigger pulse.
// - Raw time-out flag holds until software writes its clear bit.
// - With the mask bit set, time-out also sets the masked flag.
// - A lower load write while running takes effect next cycle.
// - With stall set, counting freezes while the debugger halts.
module gp_timer
   import gp_timer_pkg::*;
(
   // Clock, reset, clock enable
   input  wire logic              mclk_i,
   input  wire logic              rstn_i,
   input  wire logic              ce_i,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   // Debug and events
   input  wire logic              debug_halt_i,
   output logic                   irq_o,
   output logic                   trig_lower_o,
   output logic                   trig_upper_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [2:0]        cfg_reg;
   logic [1:0]        lo_mode_reg, hi_mode_reg;
   half_ctl_t         lo_ctl_reg, hi_ctl_reg;
   half_pair_t        ilr_reg, cnt_reg, cnt_next;
   logic [7:0]        lo_pre_reg, hi_pre_reg;
   logic              lo_raw_reg, hi_raw_reg, lo_raw_next, hi_raw_next;
   logic              lo_mask_reg, hi_mask_reg;
   logic              awready_reg, wready_reg, bvalid_reg;
   logic [1:0]        bresp_reg, rresp_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]       wdata_reg, rdata_reg;
   logic [3:0]        wstrb_reg;
   logic              arready_reg, rvalid_reg;
   logic              irq_reg, trig_lo_reg, trig_hi_reg;
   logic              is32, is16, run32, run_lo16, run_hi16;
   logic              to_lo, to_hi, wr_go;
   logic [31:0]       wmask, wd;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic mode_ok(input logic [1:0] m);
      return (m == MODE_ONESHOT) || (m == MODE_PERIODIC);
   endfunction : mode_ok
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      return (w == OFF_CFG) || (w == OFF_LO_MODE) || (w == OFF_HI_MODE)
          || (w == OFF_CTL) || (w == OFF_IMR) || (w == OFF_RIS)
          || (w == OFF_MIS) || (w == OFF_ICR) || (w == OFF_LO_ILR)
          || (w == OFF_HI_ILR) || (w == OFF_LO_PRE) || (w == OFF_HI_PRE)
          || (w == OFF_LO_CNT) || (w == OFF_HI_CNT);
   endfunction : is_mapped
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      return {a[7:2], 2'b00} == off;
   endfunction : hit
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (hit(a, OFF_CFG))     r[2:0] = cfg_reg;
      if (hit(a, OFF_LO_MODE)) r[1:0] = lo_mode_reg;
      if (hit(a, OFF_HI_MODE)) r[1:0] = hi_mode_reg;
      if (hit(a, OFF_CTL))
      begin
         r[CTL_LO_EN]    = lo_ctl_reg.en;
         r[CTL_LO_STALL] = lo_ctl_reg.stall;
         r[CTL_HI_EN]    = hi_ctl_reg.en;
         r[CTL_HI_STALL] = hi_ctl_reg.stall;
      end
      if (hit(a, OFF_IMR))
      begin
         r[IRQ_LO_TO] = lo_mask_reg;
         r[IRQ_HI_TO] = hi_mask_reg;
      end
      if (hit(a, OFF_RIS))
      begin
         r[IRQ_LO_TO] = lo_raw_reg;
         r[IRQ_HI_TO] = hi_raw_reg;
      end
      if (hit(a, OFF_MIS))
      begin
         r[IRQ_LO_TO] = lo_raw_reg & lo_mask_reg;
         r[IRQ_HI_TO] = hi_raw_reg & hi_mask_reg;
      end
      if (hit(a, OFF_LO_ILR))
         r = is16 ? {16'h0000, ilr_reg.lo} : ilr_reg;
      if (hit(a, OFF_HI_ILR))  r[15:0] = ilr_reg.hi;
      if (hit(a, OFF_LO_PRE))  r[7:0]  = lo_pre_reg;
      if (hit(a, OFF_HI_PRE))  r[7:0]  = hi_pre_reg;
      if (hit(a, OFF_LO_CNT))
         r = is16 ? {16'h0000, cnt_reg.lo} : cnt_reg;
      if (hit(a, OFF_HI_CNT))  r[15:0] = cnt_reg.hi;
      return r;
   endfunction : read_word

   // ----------------------------------------------------------------
   // Mode decode and zero detection
   // ----------------------------------------------------------------
   always_comb
   begin
      is32     = (cfg_reg == CFG_32_TIMER);
      is16     = (cfg_reg == CFG_16_SPLIT);
      // Upper mode and enable play no part when joined
      run32    = is32 && lo_ctl_reg.en && mode_ok(lo_mode_reg)
                 && !(lo_ctl_reg.stall && debug_halt_i);
      run_lo16 = is16 && lo_ctl_reg.en && mode_ok(lo_mode_reg)
                 && !(lo_ctl_reg.stall && debug_halt_i);
      run_hi16 = is16 && hi_ctl_reg.en && mode_ok(hi_mode_reg)
                 && !(hi_ctl_reg.stall && debug_halt_i);
      to_lo    = run32 ? (cnt_reg == 32'h0000_0000)
                       : (run_lo16 && (cnt_reg.lo == 16'h0000));
      to_hi    = run_hi16 && (cnt_reg.hi == 16'h0000);
   end

   // ----------------------------------------------------------------
   // Write data merge with byte strobes
   // ----------------------------------------------------------------
   always_comb
   begin
      wr_go = !awready_reg && !wready_reg && !bvalid_reg;
      for (int i = 0; i < 4; i++)
         wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
      wd = (read_word(awaddr_reg) & ~wmask) | (wdata_reg & wmask);
   end

   // ----------------------------------------------------------------
   // Counter next value
   // ----------------------------------------------------------------
   always_comb
   begin
      cnt_next = cnt_reg;
      if (run32)
         cnt_next = to_lo ? ilr_reg
                          : half_pair_t'(cnt_reg - 32'h1);
      if (run_lo16)
         cnt_next.lo = to_lo ? ilr_reg.lo : cnt_reg.lo - 16'h1;
      if (run_hi16)
         cnt_next.hi = to_hi ? ilr_reg.hi : cnt_reg.hi - 16'h1;
      if (wr_go && hit(awaddr_reg, OFF_LO_ILR))
      begin
         cnt_next.lo = wd[15:0];
         if (!is16)
            cnt_next.hi = wd[31:16];
      end
      if (wr_go && is16 && hit(awaddr_reg, OFF_HI_ILR))
         cnt_next.hi = wd[15:0];
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_reg <= {CNT_RST, CNT_RST};
      else if (ce_i)
         cnt_reg <= cnt_next;
   end

   // ----------------------------------------------------------------
   // Configuration, mode, load and prescale registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_reg     <= CFG_RST;
         lo_mode_reg <= MODE_RST;
         hi_mode_reg <= MODE_RST;
         ilr_reg     <= {ILR_RST, ILR_RST};
         lo_pre_reg  <= PRE_RST;
         hi_pre_reg  <= PRE_RST;
      end
      else if (ce_i && wr_go)
      begin
         if (hit(awaddr_reg, OFF_CFG))     cfg_reg     <= wd[2:0];
         if (hit(awaddr_reg, OFF_LO_MODE)) lo_mode_reg <= wd[1:0];
         if (hit(awaddr_reg, OFF_HI_MODE)) hi_mode_reg <= wd[1:0];
         if (hit(awaddr_reg, OFF_LO_ILR))
         begin
            ilr_reg.lo <= wd[15:0];
            if (!is16)
               ilr_reg.hi <= wd[31:16];
         end
         if (hit(awaddr_reg, OFF_HI_ILR))  ilr_reg.hi  <= wd[15:0];
         if (hit(awaddr_reg, OFF_LO_PRE))  lo_pre_reg  <= wd[7:0];
         if (hit(awaddr_reg, OFF_HI_PRE))  hi_pre_reg  <= wd[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Control register; one-shot expiry clears enable
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lo_ctl_reg <= '0;
         hi_ctl_reg <= '0;
      end
      else if (ce_i)
      begin
         if (wr_go && hit(awaddr_reg, OFF_CTL))
         begin
            lo_ctl_reg.en    <= wd[CTL_LO_EN];
            lo_ctl_reg.stall <= wd[CTL_LO_STALL];
            hi_ctl_reg.en    <= wd[CTL_HI_EN];
            hi_ctl_reg.stall <= wd[CTL_HI_STALL];
         end
         else
         begin
            if (to_lo && lo_mode_reg == MODE_ONESHOT)
               lo_ctl_reg.en <= 1'b0;
            if (to_hi && hi_mode_reg == MODE_ONESHOT)
               hi_ctl_reg.en <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Time-out flags, mask, interrupt and triggers
   // ----------------------------------------------------------------
   always_comb
   begin
      lo_raw_next = lo_raw_reg;
      hi_raw_next = hi_raw_reg;
      if (wr_go && hit(awaddr_reg, OFF_ICR))
      begin
         lo_raw_next = lo_raw_reg & ~wd[IRQ_LO_TO];
         hi_raw_next = hi_raw_reg & ~wd[IRQ_HI_TO];
      end
      // Set wins over a clear in the same cycle
      lo_raw_next = lo_raw_next | to_lo;
      hi_raw_next = hi_raw_next | to_hi;
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lo_raw_reg  <= 1'b0;
         hi_raw_reg  <= 1'b0;
         lo_mask_reg <= 1'b0;
         hi_mask_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         lo_raw_reg <= lo_raw_next;
         hi_raw_reg <= hi_raw_next;
         if (wr_go && hit(awaddr_reg, OFF_IMR))
         begin
            lo_mask_reg <= wd[IRQ_LO_TO];
            hi_mask_reg <= wd[IRQ_HI_TO];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         irq_reg     <= 1'b0;
         trig_lo_reg <= 1'b0;
         trig_hi_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_reg     <= (lo_raw_reg & lo_mask_reg)
                        | (hi_raw_reg & hi_mask_reg);
         trig_lo_reg <= to_lo;
         trig_hi_reg <= to_hi;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end
      else if (ce_i)
      begin
         if (awready_reg && s_axi_awvalid_i)
         begin
            awaddr_reg  <= s_axi_awaddr_i;
            awready_reg <= 1'b0;
         end
         if (wready_reg && s_axi_wvalid_i)
         begin
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
            wready_reg <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready_i)
         begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         if (arready_reg && s_axi_arvalid_i)
         begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= read_word(s_axi_araddr_i);
            rresp_reg   <= is_mapped(s_axi_araddr_i) ? RESP_OKAY
                                                     : RESP_SLVERR;
         end
         else if (rvalid_reg && s_axi_rready_i)
         begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign irq_o           = irq_reg;
   assign trig_lower_o    = trig_lo_reg;
   assign trig_upper_o    = trig_hi_reg;

endmodule : gp_timer

/* File: rtl/gp_timer_pkg.sv */
// Constants and types shared by the general-purpose timer block
package gp_timer_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  OFF_CFG        = 8'h00;
   localparam logic [7:0]  OFF_LO_MODE    = 8'h04;
   localparam logic [7:0]  OFF_HI_MODE    = 8'h08;
   localparam logic [7:0]  OFF_CTL        = 8'h0C;
   localparam logic [7:0]  OFF_IMR        = 8'h18;
   localparam logic [7:0]  OFF_RIS        = 8'h1C;
   localparam logic [7:0]  OFF_MIS        = 8'h20;
   localparam logic [7:0]  OFF_ICR        = 8'h24;
   localparam logic [7:0]  OFF_LO_ILR     = 8'h28;
   localparam logic [7:0]  OFF_HI_ILR     = 8'h2C;
   localparam logic [7:0]  OFF_LO_PRE     = 8'h38;
   localparam logic [7:0]  OFF_HI_PRE     = 8'h3C;
   localparam logic [7:0]  OFF_LO_CNT     = 8'h48;
   localparam logic [7:0]  OFF_HI_CNT     = 8'h4C;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [15:0] CNT_RST        = 16'hFFFF;
   localparam logic [15:0] ILR_RST        = 16'hFFFF;
   localparam logic [7:0]  PRE_RST        = 8'h00;
   localparam logic [2:0]  CFG_32_TIMER   = 3'h0;
   localparam logic [2:0]  CFG_32_RTC     = 3'h1;
   localparam logic [2:0]  CFG_16_SPLIT   = 3'h4;
   localparam logic [2:0]  CFG_RST        = 3'h0;
   localparam logic [1:0]  MODE_ONESHOT   = 2'h1;
   localparam logic [1:0]  MODE_PERIODIC  = 2'h2;
   localparam logic [1:0]  MODE_RST       = 2'h0;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          CTL_LO_EN      = 0;
   localparam int          CTL_LO_STALL   = 1;
   localparam int          CTL_HI_EN      = 8;
   localparam int          CTL_HI_STALL   = 9;
   localparam int          IRQ_LO_TO      = 0;
   localparam int          IRQ_HI_TO      = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } half_pair_t;

   typedef struct packed {
      logic stall;
      logic en;
   } half_ctl_t;

endpackage : gp_timer_pkg

/* File: sim/axi_lite_master.sv */
// Processor-side register bus master model
module axi_lite_master
(
   input  wire logic        mclk_i,
   // Write channels
   output logic [7:0]       awaddr_o = 8'h00,
   output logic             awvalid_o = 1'b0,
   input  wire logic        awready_i,
   output logic [31:0]      wdata_o = 32'h0,
   output logic             wvalid_o = 1'b0,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output logic             bready_o = 1'b0,
   // Read channels
   output logic [7:0]       araddr_o = 8'h00,
   output logic             arvalid_o = 1'b0,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output logic             rready_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;

   // Released payload is inverted so stale values never match
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge mclk_i);
      awaddr_o <= a;
      wdata_o <= d;
      awvalid_o <= 1'b1;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge mclk_i);
         if (!aw_ok && awready_i)
         begin
            aw_ok = 1;
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
         end
         if (!w_ok && wready_i)
         begin
            w_ok = 1;
            wvalid_o <= 1'b0;
            wdata_o <= ~d;
         end
      end
      do @(posedge mclk_i); while (bvalid_i !== 1'b1);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge mclk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do @(posedge mclk_i); while (arready_i !== 1'b1);
      arvalid_o <= 1'b0;
      araddr_o <= ~a;
      do @(posedge mclk_i); while (rvalid_i !== 1'b1);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask : rd
endmodule : axi_lite_master

/* File: sim/gp_timer_chk.sv */
// Handshake and event checks on the timer block ports
module gp_timer_chk
   import gp_timer_pkg::*;
(
   // Clock, reset, enable
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        ce_i,
   // Register bus
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   // Events
   input wire logic        irq_o,
   input wire logic        trig_lower_o,
   input wire logic        trig_upper_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
          && $stable(s_axi_rresp_o))
      else $error("read data dropped early");
   AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o && ce_i
      |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_B_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o
      && s_axi_wvalid_i && s_axi_wready_o && ce_i ##1 ce_i
      |=> s_axi_bvalid_o)
      else $error("write answer late");
   AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken while answer pending");
   AST_AW_BLOCK: assert property (s_axi_bvalid_o
      |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while answer pending");
   AST_CE_FREEZE: assert property (!ce_i |=> $stable(irq_o)
      && $stable(trig_lower_o) && $stable(trig_upper_o))
      else $error("outputs moved with enable low");
   AST_RESET_IDLE: assert property ($rose(rstn_i) |->
      !irq_o && !trig_lower_o && !trig_upper_o)
      else $error("events active after reset");

   // -----------------------------------------------------------
   // Coverage
   // -----------------------------------------------------------
   cover property (trig_lower_o);
   cover property (trig_upper_o);
   cover property (irq_o);
   cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule : gp_timer_chk

bind gp_timer gp_timer_chk chk_i (.mclk_i, .rstn_i, .ce_i,
   .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
   .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .irq_o, .trig_lower_o, .trig_upper_o);

/* File: sim/gp_timer_test.sv */
// Self-checking bench for the general-purpose timer
module gp_timer_test
   import gp_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        ce_i = 1'b1;
   logic        halt = 1'b0;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        irq, trig_lower, trig_upper;
   int          failures = 0;
   int          checks = 0;
   int          up_cnt = 0;
   int          n;

   always #2 mclk_i = ~mclk_i;
   always @(negedge mclk_i) if (trig_upper === 1'b1) up_cnt++;

   axi_lite_master bus (.mclk_i, .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid),
      .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
      .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
      .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
      .rvalid_i(rvalid), .rready_o(rready));

   gp_timer DUT (.mclk_i, .rstn_i, .ce_i, .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .debug_halt_i(halt), .irq_o(irq), .trig_lower_o(trig_lower),
      .trig_upper_o(trig_upper));

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      bus.wr(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      bus.rd(a, d, r);
      chk(d, e);
   endtask : rdc

   task automatic wait_trig(input bit up, input int lim, output int k);
      k = 0;
      do
      begin
         @(negedge mclk_i);
         k++;
      end
      while (((up ? trig_upper : trig_lower) !== 1'b1) && k < lim);
   endtask : wait_trig

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset;
      rdc(OFF_CFG, 32'h0);
      rdc(OFF_CTL, 32'h0);
      rdc(OFF_LO_MODE, 32'h0);
      rdc(OFF_IMR, 32'h0);
      rdc(OFF_HI_ILR, 32'h0000_FFFF);
      rdc(OFF_LO_CNT, 32'hFFFF_FFFF);
      rdc(OFF_LO_PRE, 32'h0);
      rdc(OFF_HI_PRE, 32'h0);
   endtask : t_reset

   task automatic t_oneshot;
      wr(OFF_LO_ILR, 32'h0001_0002);
      rdc(OFF_HI_ILR, 32'h0000_0001);
      rdc(OFF_LO_CNT, 32'h0001_0002);
      wr(OFF_LO_MODE, 32'(MODE_ONESHOT));
      wr(OFF_LO_ILR, 32'h3);
      wr(OFF_IMR, 32'h1);
      wr(OFF_CTL, 32'h1);
      wait_trig(0, 20, n);
      chk(32'(trig_lower), 32'h1);
      rdc(OFF_CTL, 32'h0);
      rdc(OFF_LO_CNT, 32'h3);
      rdc(OFF_RIS, 32'h1);
      rdc(OFF_MIS, 32'h1);
      chk(32'(irq), 32'h1);
      wr(OFF_ICR, 32'h1);
      rdc(OFF_RIS, 32'h0);
      chk(32'(irq), 32'h0);
   endtask : t_oneshot

   task automatic t_periodic;
      wr(OFF_IMR, 32'h0);
      wr(OFF_HI_MODE, 32'(MODE_ONESHOT));
      wr(OFF_LO_MODE, 32'(MODE_PERIODIC));
      wr(OFF_LO_ILR, 32'h4);
      wr(OFF_CTL, 32'h1);
      wait_trig(0, 20, n);
      wait_trig(0, 20, n);
      chk(32'(n), 32'h5);
      rdc(OFF_CTL, 32'h1);
      rdc(OFF_RIS, 32'h1);
      rdc(OFF_MIS, 32'h0);
      chk(32'(irq), 32'h0);
      wr(OFF_LO_ILR, 32'h0000_0200);
      wr(OFF_LO_ILR, 32'h2);
      wait_trig(0, 20, n);
      chk(32'(trig_lower), 32'h1);
      wait_trig(0, 20, n);
      chk(32'(n), 32'h3);
      chk(32'(up_cnt), 32'h0);
   endtask : t_periodic

   task automatic t_stall;
      logic [31:0] c0, c1;
      logic [1:0]  r;
      @(posedge mclk_i) halt <= 1'b1;
      wr(OFF_CTL, 32'h3);
      repeat (3) @(negedge mclk_i);
      wait_trig(0, 20, n);
      chk(32'(n), 32'd20);
      bus.rd(OFF_LO_CNT, c0, r);
      bus.rd(OFF_LO_CNT, c1, r);
      chk(c1, c0);
      @(posedge mclk_i) halt <= 1'b0;
      wait_trig(0, 10, n);
      chk(32'(trig_lower), 32'h1);
      @(posedge mclk_i) ce_i <= 1'b0;
      wait_trig(0, 20, n);
      chk(32'(n), 32'd20);
      @(posedge mclk_i) ce_i <= 1'b1;
      wr(OFF_CTL, 32'h0);
   endtask : t_stall

   task automatic t_split;
      logic [31:0] d;
      logic [1:0]  r;
      wr(OFF_ICR, 32'h0000_0101);
      wr(OFF_CFG, 32'(CFG_16_SPLIT));
      wr(OFF_HI_ILR, 32'h3);
      wr(OFF_CTL, 32'h0000_0100);
      wait_trig(1, 20, n);
      chk(32'(trig_upper), 32'h1);
      rdc(OFF_RIS, 32'h0000_0100);
      wr(OFF_CFG, 32'(CFG_32_RTC));
      rdc(OFF_CFG, 32'h1);
      bus.wr(8'h80, 32'h0000_00A5, r);
      chk(32'(r), 32'(RESP_SLVERR));
      bus.rd(8'h80, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask : t_split

   task automatic wrap_up;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_oneshot();
      t_periodic();
      t_stall();
      t_split();
      wrap_up();
   end

   initial
   begin
      repeat (5000) @(posedge mclk_i);
      failures++;
      wrap_up();
   end
endmodule : gp_timer_test
